// [hdl/luma_histo_pkg.sv]
// Constants, register map and carrier types of the luminance histogram unit.
// Assumes one pixel clock domain shared with the controller register port.
package luma_histo_pkg;

    // ------------------------------------------------------------------
    // Register map (read and write spaces are decoded separately)
    // ------------------------------------------------------------------
    localparam logic [9:0] ADR_BIN_RD    = 10'h317;
    localparam logic [9:0] ADR_YMIN      = 10'h318;
    localparam logic [9:0] ADR_YMAX      = 10'h319;
    localparam logic [9:0] ADR_UMIN      = 10'h31A;
    localparam logic [9:0] ADR_UMAX      = 10'h31B;
    localparam logic [9:0] ADR_VMIN      = 10'h31C;
    localparam logic [9:0] ADR_VMAX      = 10'h31D;
    localparam logic [9:0] ADR_PEAK      = 10'h31E;
    localparam logic [9:0] ADR_BLACK_LVL = 10'h31F;
    localparam logic [9:0] ADR_DC_SHIFT  = 10'h32A;
    localparam logic [9:0] ADR_TABLE_WR  = 10'h32B;
    localparam logic [9:0] ADR_THRESH    = 10'h32C;
    localparam logic [9:0] ADR_SPLIT     = 10'h32D;
    localparam logic [9:0] ADR_HCTRL     = 10'h32E;
    localparam logic [9:0] ADR_CCTRL     = 10'h330;
    localparam logic [9:0] ADR_WIN_HB    = 10'h331;
    localparam logic [9:0] ADR_WIN_HE    = 10'h332;
    localparam logic [9:0] ADR_WIN_VB    = 10'h333;
    localparam logic [9:0] ADR_WIN_VE    = 10'h334;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int HC_GAIN_LSB  = 0;
    localparam int HC_DENOISE   = 4;
    localparam int HC_F121      = 5;
    localparam int HC_F10201    = 6;
    localparam int CC_ROUND     = 0;
    localparam int CC_RATIO     = 1;
    localparam int CC_POSITIVE  = 3;
    localparam int CC_GAIN_LSB  = 5;

    // ------------------------------------------------------------------
    // Sizes and counts
    // ------------------------------------------------------------------
    localparam int TABLE_N       = 32;
    localparam int BLACK_FILT_SH = 3;
    localparam logic [15:0] CNT_SAT = 16'hFFFF;

    // Pixel carrier and double-buffered configuration set
    typedef struct packed {
        logic [7:0] y;
        logic [7:0] u;
        logic [7:0] v;
    } pix_t;

    typedef struct packed {
        logic [7:0] dc;
        logic [7:0] thr;
        logic [7:0] split;
        logic [6:0] cc;
        logic [7:0] hb;
        logic [7:0] he;
        logic [8:0] vb;
        logic [8:0] ve;
    } cfg_t;

    typedef struct packed {
        logic [7:0] ymin;
        logic [7:0] ymax;
        logic [7:0] umin;
        logic [7:0] umax;
        logic [7:0] vmin;
        logic [7:0] vmax;
    } mm_t;

    // Reset values
    localparam cfg_t CFG_RST   = '{dc: 8'h00, thr: 8'h00, split: 8'h00, cc: 7'h00,
                                   hb: 8'h00, he: 8'hFF, vb: 9'h000, ve: 9'h1FF};
    localparam mm_t  MM_INIT   = '{ymin: 8'hFF, ymax: 8'h00, umin: 8'hFF, umax: 8'h00,
                                   vmin: 8'hFF, vmax: 8'h00};
    localparam logic [6:0] HCTRL_RST = 7'h00;
    localparam logic [7:0] BLACK_RST = 8'h00;

endpackage : luma_histo_pkg

// [hdl/luma_histogram_processor.sv]
// Luminance histogram analysis and modification unit.
// Assumes FIELD_RST, LINE_START and the pixel stream come from logic on CLK,
// and the controller drives one-cycle read and write strobes on CLK.
//
// What this block does
// RQ1: Signed DC offset added to luminance.
// RQ2: Table of 32 signed bytes, one address.
// RQ3: First table write after field resets pointer.
// RQ4: Count sample only if step exceeds threshold.
// RQ5: Pixels left of split point, steps 4, untouched.
// RQ6: Gain 0..15 in low bits, not buffered.
// RQ7: Bits 4,5,6: denoise, 1:2:1, 1:0:2:0:1 filters.
// RQ8: Chroma bit 0: truncate or round output.
// RQ9: Chroma bit 1: ratio limit 64 or 128.
// RQ10: Chroma bit 3: follow always or positive only.
// RQ11: Bits 6..5: chroma gain 0,1/2,1,2.
// RQ12: Window start/stop registers, all double buffered.
// RQ13: First bin read after field resets pointer.
// RQ14: Report previous field Y/U/V minima, maxima.
// RQ15: Report largest bin count of previous field.
// RQ16: Report filtered luminance minimum as black level.
// RQ17: Read and write spaces decoded separately.
// RQ18: Field results latched at each field boundary.
`timescale 1ns/1ps
module luma_histogram_processor
    import luma_histo_pkg::*;
(
    // Clock and reset
    input  logic       CLK,
    input  logic       RSTN,
    // Controller register port
    input  logic [9:0] ADDR,
    input  logic       WR_STB,
    input  logic [8:0] WR_DATA,
    input  logic       RD_STB,
    output logic [7:0] RD_DATA,
    // Video timing
    input  logic       FIELD_RST,
    input  logic       LINE_START,
    // Pixel stream
    input  logic       PIX_VALID,
    input  pix_t       PIX_IN,
    output logic       PIX_OUT_VALID,
    output pix_t       PIX_OUT
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] absdiff(input logic [7:0] a, input logic [7:0] b);
        absdiff = (a > b) ? a - b : b - a;
    endfunction : absdiff

    // Gain g keeps the raw count at 15 and halves it per step below
    function automatic logic [7:0] scale_cnt(input logic [15:0] c, input logic [3:0] g);
        logic [15:0] s;
        s = c >> (4'hF - g);
        scale_cnt = (s > 16'h00FF) ? 8'hFF : s[7:0];
    endfunction : scale_cnt

    function automatic logic [7:0] clamp8(input logic signed [21:0] x);
        clamp8 = (x < 0) ? 8'h00 : ((x > 22'sd255) ? 8'hFF : x[7:0]);
    endfunction : clamp8

    // Chroma moves by its distance from neutral times the gained luma change
    function automatic logic [7:0] chroma_follow(input logic [7:0] c, input logic signed [11:0] dg,
                                                 input logic ratio, input logic rnd);
        logic signed [21:0] cu;
        logic signed [21:0] p;
        cu = $signed({14'h0000, c}) - 22'sd128;
        p  = cu * $signed({{10{dg[11]}}, dg});
        if (rnd)
            p = p + (ratio ? 22'sd64 : 22'sd32);
        p = ratio ? (p >>> 7) : (p >>> 6);
        chroma_follow = clamp8($signed({14'h0000, c}) + p);
    endfunction : chroma_follow

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_s1_q;
    logic rst_n;

    // Two-stage release of the asynchronous reset
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    logic w_dc, w_tbl, w_thr, w_split, w_hctrl, w_cc, w_hb, w_he, w_vb, w_ve;
    logic r_bin;

    // Write space only looks at the write strobe, read space at the read strobe
    assign w_dc    = WR_STB && (ADDR == ADR_DC_SHIFT); // [RQ17]
    assign w_tbl   = WR_STB && (ADDR == ADR_TABLE_WR);
    assign w_thr   = WR_STB && (ADDR == ADR_THRESH);
    assign w_split = WR_STB && (ADDR == ADR_SPLIT);
    assign w_hctrl = WR_STB && (ADDR == ADR_HCTRL);
    assign w_cc    = WR_STB && (ADDR == ADR_CCTRL);
    assign w_hb    = WR_STB && (ADDR == ADR_WIN_HB);
    assign w_he    = WR_STB && (ADDR == ADR_WIN_HE);
    assign w_vb    = WR_STB && (ADDR == ADR_WIN_VB);
    assign w_ve    = WR_STB && (ADDR == ADR_WIN_VE);
    assign r_bin   = RD_STB && (ADDR == ADR_BIN_RD); // [RQ17]

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    cfg_t       cfg_s_q;
    cfg_t       cfg_q;
    logic [6:0] hctrl_q;

    // Shadow set takes writes; active set loads at the field boundary
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            cfg_s_q <= CFG_RST;
            cfg_q   <= CFG_RST;
            hctrl_q <= HCTRL_RST;
        end else begin
            if (w_dc)    cfg_s_q.dc    <= WR_DATA[7:0];
            if (w_thr)   cfg_s_q.thr   <= WR_DATA[7:0];
            if (w_split) cfg_s_q.split <= WR_DATA[7:0];
            if (w_cc)    cfg_s_q.cc    <= WR_DATA[6:0];
            if (w_hb)    cfg_s_q.hb    <= WR_DATA[7:0]; // [RQ12]
            if (w_he)    cfg_s_q.he    <= WR_DATA[7:0];
            if (w_vb)    cfg_s_q.vb    <= WR_DATA;
            if (w_ve)    cfg_s_q.ve    <= WR_DATA;
            if (FIELD_RST) cfg_q <= cfg_s_q;              // [RQ12]
            if (w_hctrl) hctrl_q <= WR_DATA[6:0];         // [RQ6]
        end
    end

    logic [3:0]  bin_gain_sel;
    logic        denoise_enable, f121_on, f10201_on;
    logic        cc_round, cc_ratio, chroma_follow_positive;
    logic [1:0]  chroma_gain_sel;

    // Control fields
    assign bin_gain_sel           = hctrl_q[HC_GAIN_LSB +: 4]; // [RQ6]
    assign denoise_enable         = hctrl_q[HC_DENOISE];       // [RQ7]
    assign f121_on                = hctrl_q[HC_F121];
    assign f10201_on              = hctrl_q[HC_F10201];
    assign cc_round               = cfg_q.cc[CC_ROUND];        // [RQ8]
    assign cc_ratio               = cfg_q.cc[CC_RATIO];        // [RQ9]
    assign chroma_follow_positive = cfg_q.cc[CC_POSITIVE];     // [RQ10]
    assign chroma_gain_sel        = cfg_q.cc[CC_GAIN_LSB +: 2];

    // ------------------------------------------------------------------
    // Table and bin pointers
    // ------------------------------------------------------------------
    logic [4:0] tbl_ptr_q, rd_ptr_q, tbl_idx, rd_idx;
    logic       tbl_first_q, rd_first_q;

    assign tbl_idx = tbl_first_q ? 5'h00 : tbl_ptr_q; // [RQ3]
    assign rd_idx  = rd_first_q ? 5'h00 : rd_ptr_q;   // [RQ13]

    // Field reset re-arms both pointers; it wins over a same-cycle access
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            tbl_ptr_q   <= 5'h00;
            rd_ptr_q    <= 5'h00;
            tbl_first_q <= 1'b1;
            rd_first_q  <= 1'b1;
        end else begin
            if (w_tbl) tbl_ptr_q <= tbl_idx + 5'h01;           // [RQ3]
            if (r_bin) rd_ptr_q  <= rd_idx + 5'h01;            // [RQ13]
            tbl_first_q <= FIELD_RST || (tbl_first_q && !w_tbl);
            rd_first_q  <= FIELD_RST || (rd_first_q && !r_bin);
        end
    end

    // ------------------------------------------------------------------
    // Pixel position and taps
    // ------------------------------------------------------------------
    logic [9:0] h_cnt_q, h_cur;
    logic [8:0] v_cnt_q, v_cur;
    pix_t       tap_q [4];
    logic [9:0] hpos_q [2];

    assign h_cur = LINE_START ? 10'h000 : h_cnt_q;
    assign v_cur = LINE_START ? v_cnt_q + 9'h001 : v_cnt_q;

    // Line counter per line start; sample counter and a four-sample delay line per valid sample
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            h_cnt_q <= 10'h000;
            v_cnt_q <= 9'h000;
            tap_q   <= '{default: '0};
            hpos_q  <= '{default: '0};
        end else begin
            if (FIELD_RST) v_cnt_q <= 9'h000;
            else           v_cnt_q <= v_cur;
            if (PIX_VALID) begin
                h_cnt_q   <= h_cur + 10'h001;
                tap_q     <= '{PIX_IN, tap_q[0], tap_q[1], tap_q[2]};
                hpos_q    <= '{h_cur, hpos_q[0]};
            end else if (LINE_START) begin
                h_cnt_q   <= 10'h000;
            end
        end
    end

    // ------------------------------------------------------------------
    // Histogram and field measurements
    // ------------------------------------------------------------------
    logic        in_win, hit;
    logic [4:0]  bin;
    logic [15:0] cnt_q [TABLE_N];
    logic [15:0] bank_q [TABLE_N];
    logic [7:0]  lut_q [TABLE_N];
    logic [15:0] cnt_bin, cnt_inc, peak_run_q, peak_rep_q;
    mm_t         mm_run_q, mm_rep_q;
    logic [7:0]  black_q;

    assign in_win  = (h_cur[9:2] >= cfg_q.hb) && (h_cur[9:2] <= cfg_q.he)
                  && (v_cur >= cfg_q.vb) && (v_cur <= cfg_q.ve);
    assign hit     = PIX_VALID && in_win && (absdiff(PIX_IN.y, tap_q[0].y) > cfg_q.thr); // [RQ4]
    assign bin     = PIX_IN.y[7:3];
    assign cnt_bin = cnt_q[bin];
    assign cnt_inc = (cnt_bin == CNT_SAT) ? CNT_SAT : cnt_bin + 16'h0001;

    // Per-bin counters, field banks and the transfer table
    for (genvar gi = 0; gi < TABLE_N; gi++) begin : g_bin
        always_ff @(posedge CLK or negedge rst_n) begin
            if (!rst_n) begin
                cnt_q[gi]  <= 16'h0000;
                bank_q[gi] <= 16'h0000;
                lut_q[gi]  <= 8'h00;
            end else begin
                if (FIELD_RST) begin
                    bank_q[gi] <= cnt_q[gi];                   // [RQ18]
                    cnt_q[gi]  <= 16'h0000;
                end else if (hit && (bin == 5'(gi))) begin
                    cnt_q[gi]  <= cnt_inc;                     // [RQ4]
                end
                if (w_tbl && (tbl_idx == 5'(gi)))
                    lut_q[gi] <= WR_DATA[7:0];                 // [RQ2]
            end
        end
    end

    logic signed [8:0] black_diff;
    assign black_diff = $signed({1'b0, mm_run_q.ymin}) - $signed({1'b0, black_q});

    // Running extremes, peak and black level, banked at the field boundary
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            mm_run_q   <= MM_INIT;
            mm_rep_q   <= MM_INIT;
            peak_run_q <= 16'h0000;
            peak_rep_q <= 16'h0000;
            black_q    <= BLACK_RST;
        end else if (FIELD_RST) begin
            mm_rep_q   <= mm_run_q;                            // [RQ14] [RQ18]
            mm_run_q   <= MM_INIT;
            peak_rep_q <= peak_run_q;                          // [RQ15]
            peak_run_q <= 16'h0000;
            black_q    <= black_q + 8'(black_diff >>> BLACK_FILT_SH); // [RQ16]
        end else begin
            if (PIX_VALID && in_win) begin
                if (PIX_IN.y < mm_run_q.ymin) mm_run_q.ymin <= PIX_IN.y;
                if (PIX_IN.y > mm_run_q.ymax) mm_run_q.ymax <= PIX_IN.y;
                if (PIX_IN.u < mm_run_q.umin) mm_run_q.umin <= PIX_IN.u;
                if (PIX_IN.u > mm_run_q.umax) mm_run_q.umax <= PIX_IN.u;
                if (PIX_IN.v < mm_run_q.vmin) mm_run_q.vmin <= PIX_IN.v;
                if (PIX_IN.v > mm_run_q.vmax) mm_run_q.vmax <= PIX_IN.v;
            end
            if (hit && (cnt_inc > peak_run_q)) peak_run_q <= cnt_inc; // [RQ15]
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    logic [7:0] rd_val;

    // Read space; unmapped read addresses return zero
    always_comb begin
        unique case (ADDR)
            ADR_BIN_RD:    rd_val = scale_cnt(bank_q[rd_idx], bin_gain_sel); // [RQ13]
            ADR_YMIN:      rd_val = mm_rep_q.ymin;                           // [RQ14]
            ADR_YMAX:      rd_val = mm_rep_q.ymax;
            ADR_UMIN:      rd_val = mm_rep_q.umin;
            ADR_UMAX:      rd_val = mm_rep_q.umax;
            ADR_VMIN:      rd_val = mm_rep_q.vmin;
            ADR_VMAX:      rd_val = mm_rep_q.vmax;
            ADR_PEAK:      rd_val = scale_cnt(peak_rep_q, bin_gain_sel);    // [RQ15]
            ADR_BLACK_LVL: rd_val = black_q;                                // [RQ16]
            default:       rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n)      RD_DATA <= 8'h00;
        else if (RD_STB) RD_DATA <= rd_val;
    end

    // ------------------------------------------------------------------
    // Luminance modification and chroma follow (centre sample = tap 1)
    // ------------------------------------------------------------------
    logic [9:0]         rnd2;
    logic [9:0]         sum121, sum10201;
    logic [8:0]         avg2;
    logic [7:0]         yc, yf, ymod;
    logic signed [21:0] ysum;
    logic signed [9:0]  dy;
    logic signed [11:0] dg;
    logic               follow;
    logic [7:0]         uout, vout;

    assign yc       = tap_q[1].y;
    assign rnd2     = cc_round ? 10'h002 : 10'h000;
    assign sum121   = {2'b00, tap_q[0].y} + {1'b0, yc, 1'b0} + {2'b00, tap_q[2].y} + rnd2;
    assign sum10201 = {2'b00, PIX_IN.y} + {1'b0, yc, 1'b0} + {2'b00, tap_q[3].y} + rnd2;
    assign avg2     = ({1'b0, tap_q[2].y} + {1'b0, yc} + {8'h00, cc_round}) >> 1;

    // Denoise, then the wide filter, then the narrow one
    assign yf = (denoise_enable && (absdiff(yc, tap_q[2].y) <= cfg_q.thr)) ? avg2[7:0] // [RQ7]
              : f10201_on ? sum10201[9:2]
              : f121_on   ? sum121[9:2]
              : yc;

    assign ysum = $signed({14'h0000, yf}) + 22'($signed(cfg_q.dc))          // [RQ1]
                + 22'($signed(lut_q[yf[7:3]]));                             // [RQ2]
    assign ymod = clamp8(ysum);
    assign dy   = $signed({2'b00, ymod}) - $signed({2'b00, yf});
    assign follow = !chroma_follow_positive || (dy > 0);                    // [RQ10]

    // Gain 0, 1/2, 1, 2 on the luma change
    assign dg = !follow                  ? 12'sh000
              : (chroma_gain_sel == 2'h0) ? 12'sh000                       // [RQ11]
              : (chroma_gain_sel == 2'h1) ? 12'(dy >>> 1)
              : (chroma_gain_sel == 2'h2) ? 12'(dy)
              : 12'(dy) <<< 1;

    assign uout = chroma_follow(tap_q[1].u, dg, cc_ratio, cc_round);       // [RQ8] [RQ9]
    assign vout = chroma_follow(tap_q[1].v, dg, cc_ratio, cc_round);

    // Output register; left of the split point the pixel passes untouched
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            PIX_OUT       <= '0;
            PIX_OUT_VALID <= 1'b0;
        end else begin
            PIX_OUT_VALID <= PIX_VALID;
            if (PIX_VALID) begin
                if (hpos_q[1] < {cfg_q.split, 2'b00}) PIX_OUT <= tap_q[1]; // [RQ5]
                else                                   PIX_OUT <= '{ymod, uout, vout};
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);

    // First table write while the pointer is armed
    sequence s_first_write;
        w_tbl && tbl_first_q;
    endsequence

    a_table_first_idx: assert property (s_first_write |=> tbl_ptr_q == 5'h01) // [RQ3]
        else $error("first table write after field reset not at entry 0");
    a_table_ptr_step: assert property ((w_tbl && !tbl_first_q && !FIELD_RST) // [RQ3]
        |=> tbl_ptr_q == $past(tbl_ptr_q) + 5'h01)
        else $error("table pointer did not advance by one");
    a_bin_first_read: assert property ((r_bin && rd_first_q) // [RQ13]
        |=> RD_DATA == scale_cnt($past(bank_q[0]), $past(bin_gain_sel)))
        else $error("first bin read did not return bin 0");
    a_window_shadow: assert property (FIELD_RST |=> (cfg_q.hb == $past(cfg_s_q.hb)) // [RQ12]
        && (cfg_q.ve == $past(cfg_s_q.ve)))
        else $error("window not loaded at field boundary");
    a_window_hold: assert property (!FIELD_RST |=> $stable(cfg_q)) // [RQ12]
        else $error("active window changed inside a field");
    a_field_latch: assert property (FIELD_RST |=> (mm_rep_q == $past(mm_run_q)) // [RQ18]
        && (peak_rep_q == $past(peak_run_q)))
        else $error("field results not latched at field boundary");
    a_field_hold: assert property (!FIELD_RST |=> $stable(mm_rep_q) && $stable(peak_rep_q)) // [RQ18]
        else $error("field results changed inside a field");
    a_gain_direct: assert property (w_hctrl |=> bin_gain_sel == $past(WR_DATA[3:0])) // [RQ6]
        else $error("gain not effective next cycle");
    a_split_bypass: assert property ((PIX_VALID && (hpos_q[1] < {cfg_q.split, 2'b00})) // [RQ5]
        |=> PIX_OUT == $past(tap_q[1]) && PIX_OUT_VALID)
        else $error("pixel left of split point was modified");
    a_hist_thresh: assert property ((PIX_VALID && in_win && !FIELD_RST // [RQ4]
        && absdiff(PIX_IN.y, tap_q[0].y) <= cfg_q.thr) |=> cnt_q[$past(bin)] == $past(cnt_q[bin]))
        else $error("sample counted below threshold");

endmodule : luma_histogram_processor

// [verif/test_luma_histogram_processor.sv]
// Self-checking bench of the luminance histogram unit.
// Assumes the video source model on the same 20 MHz clock.
`timescale 1ns/1ps
module test_luma_histogram_processor import luma_histo_pkg::*;;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic [9:0] addr = '0;
    logic       wr_stb = 1'b0;
    logic [8:0] wr_data = '0;
    logic       rd_stb = 1'b0;
    logic [7:0] rd_data;
    logic       field_rst, line_start, pix_valid, pix_out_valid;
    pix_t       pix_in, pix_out;
    pix_t       outs[$];
    pix_t       smp[$];
    int         n_mismatch = 0;
    int         n_checks = 0;

    always #25 clk = ~clk;
    // Collect every output sample
    always @(posedge clk) if (pix_out_valid === 1'b1) outs.push_back(pix_out);

    luma_histogram_processor u_dut (.CLK(clk), .RSTN(rstn), .ADDR(addr), .WR_STB(wr_stb),
        .WR_DATA(wr_data), .RD_STB(rd_stb), .RD_DATA(rd_data), .FIELD_RST(field_rst),
        .LINE_START(line_start), .PIX_VALID(pix_valid), .PIX_IN(pix_in),
        .PIX_OUT_VALID(pix_out_valid), .PIX_OUT(pix_out));
    video_src src (.CLK(clk), .FIELD_RST(field_rst), .LINE_START(line_start),
        .PIX_VALID(pix_valid), .PIX_IN(pix_in));

    // ------------------------------------------------------------
    // Bus cycles and comparison
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [9:0] a, input logic [8:0] d);
        @(posedge clk);
        #1 addr = a;
        wr_data = d;
        wr_stb = 1'b1;
        @(posedge clk);
        #1 wr_stb = 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        #1 addr = a;
        rd_stb = 1'b1;
        @(posedge clk);
        #1 rd_stb = 1'b0;
        check(what, rd_data, exp);
    endtask : rd_chk

    function automatic pix_t mk(input logic [7:0] y);
        return '{y: y, u: y ^ 8'h55, v: ~y};
    endfunction : mk

    // Sixteen equal samples on one line, outputs collected afresh
    task automatic flat_line(input pix_t p);
        smp = {};
        repeat (16) smp.push_back(p);
        outs = {};
        src.send_line(smp);
    endtask : flat_line

    // One field of steps 0x20 apart, then the reported statistics
    task automatic test_stats();
        wr(ADR_HCTRL, 9'h00F);
        wr(ADR_THRESH, 9'h01F);
        src.field_pulse();
        smp = {};
        smp.push_back(mk(8'hF8));
        repeat (10) begin
            smp.push_back(mk(8'h10));
            smp.push_back(mk(8'h30));
        end
        smp.push_back(mk(8'h30));
        src.send_line(smp);
        src.field_pulse();
        rd_chk(ADR_YMIN, 8'h10, "ymin");
        rd_chk(ADR_YMAX, 8'hF8, "ymax");
        rd_chk(ADR_UMIN, 8'h45, "umin");
        rd_chk(ADR_UMAX, 8'hAD, "umax");
        rd_chk(ADR_VMIN, 8'h07, "vmin");
        rd_chk(ADR_VMAX, 8'hEF, "vmax");
        rd_chk(ADR_PEAK, 8'h0A, "peak");
        for (int i = 0; i < TABLE_N; i++) begin
            rd_chk(ADR_BIN_RD, (i == 2 || i == 6) ? 8'h0A : ((i == 31) ? 8'h01 : 8'h00), "bin");
        end
        wr(ADR_HCTRL, 9'h00E);
        rd_chk(ADR_PEAK, 8'h05, "peak gain 14");
        rd_chk(ADR_BLACK_LVL, 8'h1D, "black level");
        smp = {};
        smp.push_back(mk(8'h00));
        smp.push_back(mk(8'hFF));
        src.send_line(smp);
        wr(ADR_YMIN, 9'h055);
        rd_chk(ADR_YMIN, 8'h10, "ymin held");
    endtask : test_stats

    // Table after stray writes, DC shift and split on a flat line
    task automatic test_table();
        repeat (3) wr(ADR_TABLE_WR, 9'h07F);
        src.field_pulse();
        for (int k = 0; k < TABLE_N; k++) begin
            wr(ADR_TABLE_WR, 9'(k));
        end
        wr(ADR_DC_SHIFT, 9'h0FC);
        wr(ADR_SPLIT, 9'h002);
        rd_chk(ADR_DC_SHIFT, 8'h00, "write-only read");
        src.field_pulse();
        flat_line('{y: 8'h50, u: 8'h80, v: 8'h80});
        check("y h7", outs[9].y, 8'h50);
        check("y h8", outs[10].y, 8'h56);
        check("y h13", outs[15].y, 8'h56);
        check("u gain 0", outs[15].u, 8'h80);
    endtask : test_table

    // Chroma follows a luma rise of 6 with rounding, then ignores a fall
    task automatic test_chroma();
        wr(ADR_CCTRL, 9'h041);
        src.field_pulse();
        flat_line('{y: 8'h50, u: 8'hD0, v: 8'h40});
        check("u round", outs[15].u, 8'hD8);
        check("v ratio 64", outs[15].v, 8'h3A);
        wr(ADR_CCTRL, 9'h048);
        wr(ADR_DC_SHIFT, 9'h0F0);
        src.field_pulse();
        flat_line('{y: 8'h50, u: 8'hD0, v: 8'h40});
        check("y dc -16", outs[15].y, 8'h4A);
        check("u no follow", outs[15].u, 8'hD0);
    endtask : test_chroma

    task automatic end_of_test();
        $display("Checks made %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (3) @(posedge clk);
        test_stats();
        test_table();
        test_chroma();
        end_of_test();
    end

    // Watchdog, about fourteen times the expected run
    initial begin
        #200000;
        n_mismatch++;
        end_of_test();
    end
endmodule : test_luma_histogram_processor

// [verif/video_src.sv]
// Video source model: field pulses and lines of continuous samples.
// Assumes the unit's CLK; drives just after each rising edge.
`timescale 1ns/1ps
module video_src
    import luma_histo_pkg::*;
(
    // Clock
    input  wire logic CLK,
    // Timing and stream
    output logic      FIELD_RST,
    output logic      LINE_START,
    output logic      PIX_VALID,
    output pix_t      PIX_IN
);
    // Idle levels at time zero
    initial begin
        FIELD_RST = 1'b0;
        LINE_START = 1'b0;
        PIX_VALID = 1'b0;
        PIX_IN = '0;
    end

    // One-cycle field boundary pulse
    task automatic field_pulse();
        @(posedge CLK);
        #1 FIELD_RST = 1'b1;
        @(posedge CLK);
        #1 FIELD_RST = 1'b0;
    endtask : field_pulse

    // Samples back to back; released data is inverted so it is not reused
    task automatic send_line(input pix_t s[$]);
        foreach (s[i]) begin
            @(posedge CLK);
            #1 PIX_VALID = 1'b1;
            LINE_START = (i == 0);
            PIX_IN = s[i];
        end
        @(posedge CLK);
        #1 PIX_VALID = 1'b0;
        LINE_START = 1'b0;
        PIX_IN = ~PIX_IN;
        repeat (3) @(posedge CLK);
    endtask : send_line
endmodule : video_src
